// ===== core/tsx_crosspoint.sv
// Time stamp crosspoint with auxiliary NCO stamp tagging
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module tsx_crosspoint
   import tsx_pkg::*;
#(
   parameter int TS_W = TSX_TS_W,
   parameter int PER_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [TSX_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Digitizer stamps: refs, feedback, aux refs (sources 0..9)
   input wire logic [9:0] dig_valid_i,
   input wire logic [10*TS_W-1:0] dig_stamp_i,
   input wire logic [3:0] demod_sync_i,
   input wire logic [1:0] mod_sync_i,
   // Inverse user stamper stamps (sources 12..13)
   input wire logic [1:0] inv_valid_i,
   input wire logic [2*TS_W-1:0] inv_stamp_i,
   input wire logic [1:0] inv_tag_i,
   // NCO rollover pulses and NCO periods
   input wire logic [1:0] nco_roll_i,
   input wire logic [2*TS_W-1:0] nco_period_i,
   // Destination ports
   output logic [TSX_NUM_DST-1:0] dst_valid_o,
   output logic [TSX_NUM_DST*TS_W-1:0] dst_stamp_o,
   output logic [TSX_NUM_DST-1:0] dst_tag_o,
   // Nominal period per source to the digitizers
   output logic [TSX_NUM_SRC*PER_W-1:0] src_period_o
);
   // ------------------------------------------------------------
   // Legality matrix
   // ------------------------------------------------------------
   function automatic logic route_legal(input logic [3:0] src,
                                        input int dst);
      logic ok;
      ok = 1'b1;
      if (src > TSX_SRC_INV1) begin
         ok = 1'b0;
      end else if (src == TSX_SRC_FB0) begin
         ok = (dst != TSX_DST_LOOP0) && (dst != TSX_DST_COMP);
      end else if (src == TSX_SRC_FB1) begin
         ok = (dst != TSX_DST_LOOP1) && (dst != TSX_DST_COMP);
      end else if (src >= TSX_SRC_NCO0) begin
         ok = (dst != TSX_DST_COMP);
      end
      return ok;
   endfunction

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire logic [15:0] idx = paddr_i[17:2];
   wire logic acc = psel_i && penable_i;
   wire logic wr = acc && pwrite_i;
   wire logic route_hit = (idx >= TSX_IDX_ROUTE0) &&
                          (idx < TSX_IDX_ROUTE0 + 16'h0006);
   wire logic [2:0] route_n = 3'(idx - TSX_IDX_ROUTE0);
   wire logic per_hit = (idx >= TSX_IDX_PERIOD0) &&
                        (idx < TSX_IDX_PERIOD0 + 16'h000E);
   wire logic [3:0] per_n = 4'(idx - TSX_IDX_PERIOD0);
   wire logic hit_fixed = (idx == TSX_IDX_NCO0_RATIO) ||
                          (idx == TSX_IDX_NCO0_SHIFT) ||
                          (idx == TSX_IDX_NCO1_RATIO) ||
                          (idx == TSX_IDX_NCO1_SHIFT) ||
                          (idx == TSX_IDX_TAGUSE) ||
                          (idx == TSX_IDX_STATUS);
   wire logic mapped = hit_fixed || route_hit || per_hit;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [TSX_SEL_W-1:0] sel_reg [TSX_NUM_DST];
   logic [TSX_NUM_DST-1:0] en_reg;
   logic [TSX_NUM_DST-1:0] taguse_reg;
   logic [TSX_NUM_DST-1:0] reject_reg;
   logic [PER_W-1:0] per_reg [TSX_NUM_SRC];
   logic [TSX_TAG_W-1:0] ratio_reg [TSX_NUM_NCO];
   logic [TSX_TAG_W-1:0] shift_reg [TSX_NUM_NCO];

   // Illegal combinations are refused and flagged, route keeps old value
   logic [TSX_NUM_DST-1:0] wr_route_ok;
   logic [TSX_NUM_DST-1:0] wr_route_bad;
   always_comb begin
      for (int d = 0; d < TSX_NUM_DST; d++) begin
         wr_route_ok[d] = wr && route_hit && (route_n == 3'(d)) &&
                          route_legal(pwdata_i[3:0], d);
         wr_route_bad[d] = wr && route_hit && (route_n == 3'(d)) &&
                           !route_legal(pwdata_i[3:0], d);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int d = 0; d < TSX_NUM_DST; d++) begin
            sel_reg[d] <= TSX_ROUTE_SEL_RST;
         end
         en_reg <= '0;
         taguse_reg <= '0;
      end else begin
         for (int d = 0; d < TSX_NUM_DST; d++) begin
            if (wr_route_ok[d]) begin
               sel_reg[d] <= pwdata_i[3:0];
               en_reg[d] <= pwdata_i[TSX_ROUTE_EN_BIT];
            end
         end
         if (wr && idx == TSX_IDX_TAGUSE) begin
            taguse_reg <= pwdata_i[TSX_NUM_DST-1:0];
         end
      end
   end

   // Sticky reject flags; a new reject beats the write-one clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reject_reg <= '0;
      end else begin
         for (int d = 0; d < TSX_NUM_DST; d++) begin
            if (wr_route_bad[d]) begin
               reject_reg[d] <= 1'b1;
            end else if (wr && idx == TSX_IDX_STATUS && pwdata_i[d]) begin
               reject_reg[d] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int s = 0; s < TSX_NUM_SRC; s++) begin
            per_reg[s] <= '0;
         end
      end else if (wr && per_hit) begin
         per_reg[per_n] <= pwdata_i[PER_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Source assembly
   // ------------------------------------------------------------
   logic [TS_W-1:0] src_stamp [TSX_NUM_SRC];
   logic [TSX_NUM_SRC-1:0] src_valid;
   logic [TSX_NUM_SRC-1:0] src_tag;
   logic [TS_W-1:0] nco_ts_reg [TSX_NUM_NCO];
   logic [TSX_NUM_NCO-1:0] nco_v_reg;
   logic [TSX_NUM_NCO-1:0] nco_t_reg;

   genvar g;
   generate
      for (g = 0; g < 10; g++) begin : g_dig
         // One stamp per digitizer edge; refs and feedback tagged on sync events, aux never tagged
         assign src_valid[g] = dig_valid_i[g];
         assign src_stamp[g] = dig_stamp_i[g*TS_W +: TS_W];
         if (g < 4) begin : g_ref
            assign src_tag[g] = demod_sync_i[g];
         end else if (g < 6) begin : g_fb
            assign src_tag[g] = mod_sync_i[g-4];
         end else begin : g_aux
            assign src_tag[g] = 1'b0;
         end
      end
      for (g = 0; g < TSX_NUM_NCO; g++) begin : g_nco
         // NCO sources (10..11) and inverse stamper sources (12..13)
         assign src_valid[10+g] = nco_v_reg[g];
         assign src_stamp[10+g] = nco_ts_reg[g];
         assign src_tag[10+g] = nco_t_reg[g];
         assign src_valid[12+g] = inv_valid_i[g];
         assign src_stamp[12+g] = inv_stamp_i[g*TS_W +: TS_W];
         assign src_tag[12+g] = inv_tag_i[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // NCO stamp generation and tagging
   // ------------------------------------------------------------
   logic [TSX_TAG_W-1:0] cnt_reg [TSX_NUM_NCO];
   logic [TSX_NUM_NCO-1:0] shift_wr;
   logic [TSX_NUM_NCO-1:0] ratio_wr;
   assign ratio_wr[0] = wr && idx == TSX_IDX_NCO0_RATIO;
   assign ratio_wr[1] = wr && idx == TSX_IDX_NCO1_RATIO;
   assign shift_wr[0] = wr && idx == TSX_IDX_NCO0_SHIFT;
   assign shift_wr[1] = wr && idx == TSX_IDX_NCO1_SHIFT;

   generate
      for (g = 0; g < TSX_NUM_NCO; g++) begin : g_tag
         // Phase counter runs 0..N; tag at N. Shift K is taken off the
         // phase so a negative K reaches N sooner (earlier tag).
         wire logic [TSX_TAG_W-1:0] n = ratio_reg[g];
         wire logic [TSX_TAG_W-1:0] k = shift_reg[g];
         wire logic [TSX_TAG_W:0] sum = {1'b0, cnt_reg[g]} -
                                        {k[TSX_TAG_W-1], k};
         wire logic [TSX_TAG_W:0] np1 = {1'b0, n} + 17'h00001;
         wire logic [TSX_TAG_W:0] wrapped =
            sum[TSX_TAG_W] ? sum + np1 :
            (sum >= np1) ? sum - np1 : sum;
         wire logic [TSX_TAG_W-1:0] phase = wrapped[TSX_TAG_W-1:0];
         wire logic hit = (n != '0) && (phase == n);
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               cnt_reg[g] <= '0;
               ratio_reg[g] <= TSX_RATIO_RST;
               shift_reg[g] <= TSX_SHIFT_RST;
               nco_ts_reg[g] <= '0;
               nco_v_reg[g] <= 1'b0;
               nco_t_reg[g] <= 1'b0;
            end else begin
               nco_v_reg[g] <= nco_roll_i[g];
               if (ratio_wr[g]) begin
                  ratio_reg[g] <= pwdata_i[TSX_TAG_W-1:0];
                  cnt_reg[g] <= '0;
               end
               if (nco_roll_i[g]) begin
                  nco_ts_reg[g] <= nco_ts_reg[g] +
                                   nco_period_i[g*TS_W +: TS_W];
                  nco_t_reg[g] <= hit;
                  if (!ratio_wr[g]) begin
                     cnt_reg[g] <= hit ? '0 : phase + 16'h0001;
                  end
               end
               // Shift is applied at the next rollover, then cleared
               if (shift_wr[g]) begin
                  shift_reg[g] <= pwdata_i[TSX_TAG_W-1:0];
               end else if (nco_roll_i[g]) begin
                  shift_reg[g] <= '0;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Crosspoint
   // ------------------------------------------------------------
   generate
      for (g = 0; g < TSX_NUM_DST; g++) begin : g_dst
         wire logic [TSX_SEL_W-1:0] s = sel_reg[g];
         wire logic v = en_reg[g] && src_valid[s];
         wire logic t = src_tag[s];
         // Processor and stamper drop untagged; the other destinations optionally
         wire logic tag_only = (g == TSX_DST_PROC) ||
                               (g == TSX_DST_STMP) || taguse_reg[g];
         wire logic pass = v && (t || !tag_only);
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               dst_valid_o[g] <= 1'b0;
               dst_stamp_o[g*TS_W +: TS_W] <= '0;
               dst_tag_o[g] <= 1'b0;
            end else begin
               dst_valid_o[g] <= pass;
               if (pass) begin
                  dst_stamp_o[g*TS_W +: TS_W] <= src_stamp[s];
                  dst_tag_o[g] <= t;
               end
            end
         end
      end
      for (g = 0; g < TSX_NUM_SRC; g++) begin : g_per
         assign src_period_o[g*PER_W +: PER_W] = per_reg[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // APB read path; no stamp is visible here
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      if (idx == TSX_IDX_NCO0_RATIO) rd_mux[15:0] = ratio_reg[0];
      if (idx == TSX_IDX_NCO1_RATIO) rd_mux[15:0] = ratio_reg[1];
      if (idx == TSX_IDX_NCO0_SHIFT) rd_mux[15:0] = shift_reg[0];
      if (idx == TSX_IDX_NCO1_SHIFT) rd_mux[15:0] = shift_reg[1];
      if (idx == TSX_IDX_TAGUSE) rd_mux[5:0] = taguse_reg;
      if (idx == TSX_IDX_STATUS) rd_mux[5:0] = reject_reg;
      if (route_hit) rd_mux[4:0] = {en_reg[route_n], sel_reg[route_n]};
      if (per_hit) rd_mux[PER_W-1:0] = per_reg[per_n];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= '0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         // No wait state; outputs are registered from the setup phase
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !mapped;
         prdata_o <= (psel_i && !penable_i) ? rd_mux : 32'h00000000;
      end
   end
endmodule // tsx_crosspoint

// ===== core/tsx_pkg.sv
// Package of constants for the time stamp crosspoint tagger
package tsx_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int TSX_NUM_SRC = 14;
   localparam int TSX_NUM_DST = 6;
   localparam int TSX_SEL_W = 4;
   localparam int TSX_TS_W = 48;
   localparam int TSX_TAG_W = 16;
   localparam int TSX_NUM_NCO = 2;
   // ------------------------------------------------------------
   // Source indices
   // ------------------------------------------------------------
   localparam logic [3:0] TSX_SRC_REF_A = 4'h0;
   localparam logic [3:0] TSX_SRC_REF_A_ALT = 4'h1;
   localparam logic [3:0] TSX_SRC_REF_B = 4'h2;
   localparam logic [3:0] TSX_SRC_REF_B_ALT = 4'h3;
   localparam logic [3:0] TSX_SRC_FB0 = 4'h4;
   localparam logic [3:0] TSX_SRC_FB1 = 4'h5;
   localparam logic [3:0] TSX_SRC_AUX0 = 4'h6;
   localparam logic [3:0] TSX_SRC_NCO0 = 4'hA;
   localparam logic [3:0] TSX_SRC_NCO1 = 4'hB;
   localparam logic [3:0] TSX_SRC_INV0 = 4'hC;
   localparam logic [3:0] TSX_SRC_INV1 = 4'hD;
   // ------------------------------------------------------------
   // Destination indices
   // ------------------------------------------------------------
   localparam int TSX_DST_LOOP0 = 0;
   localparam int TSX_DST_LOOP1 = 1;
   localparam int TSX_DST_COMP = 2;
   localparam int TSX_DST_SKEW = 3;
   localparam int TSX_DST_PROC = 4;
   localparam int TSX_DST_STMP = 5;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [15:0] TSX_IDX_NCO0_RATIO = 16'h280B;
   localparam logic [15:0] TSX_IDX_NCO0_SHIFT = 16'h280D;
   localparam logic [15:0] TSX_IDX_NCO1_RATIO = 16'h284B;
   localparam logic [15:0] TSX_IDX_NCO1_SHIFT = 16'h284D;
   localparam logic [15:0] TSX_IDX_ROUTE0 = 16'h2900;
   localparam logic [15:0] TSX_IDX_TAGUSE = 16'h2906;
   localparam logic [15:0] TSX_IDX_STATUS = 16'h2907;
   localparam logic [15:0] TSX_IDX_PERIOD0 = 16'h2910;
   localparam int TSX_ADDR_W = 18;
   // ------------------------------------------------------------
   // Route register fields and register reset values
   // ------------------------------------------------------------
   localparam int TSX_ROUTE_EN_BIT = 4;
   localparam logic [15:0] TSX_RATIO_RST = 16'h0000;
   localparam logic [15:0] TSX_SHIFT_RST = 16'h0000;
   localparam logic [TSX_SEL_W-1:0] TSX_ROUTE_SEL_RST = 4'h0;
endpackage

// ===== bench/tsx_crosspoint_properties.sv
// Port checker for the time stamp crosspoint
`timescale 1ns/1ps
module tsx_crosspoint_properties
   import tsx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [31:0] prdata_o,
   input wire logic [9:0] dig_valid_i,
   input wire logic [1:0] inv_valid_i,
   input wire logic [1:0] nco_roll_i,
   input wire logic [TSX_NUM_DST-1:0] dst_valid_o,
   input wire logic [TSX_NUM_DST-1:0] dst_tag_o
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   setup_ready_a:
      assert property (psel_i && !penable_i |=> pready_o)
      else $error("No pready after setup");
   ready_pulse_a:
      assert property (pready_o |=> !pready_o)
      else $error("Pready longer than one cycle");
   ready_cause_a:
      assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
      else $error("Pready without setup");
   err_ready_a:
      assert property (pslverr_o |-> pready_o)
      else $error("Pslverr without pready");
   err_zero_a:
      assert property (pslverr_o |-> prdata_o == 32'h00000000)
      else $error("Refused read returns data");
   proc_tagged_a:
      assert property (dst_valid_o[TSX_DST_PROC] |-> dst_tag_o[TSX_DST_PROC])
      else $error("Untagged stamp at processor");
   stmp_tagged_a:
      assert property (dst_valid_o[TSX_DST_STMP] |-> dst_tag_o[TSX_DST_STMP])
      else $error("Untagged stamp at stamper");
   comp_source_a:
      assert property (dst_valid_o[TSX_DST_COMP] |->
         $past(dig_valid_i[3:0]) != 4'h0 || $past(dig_valid_i[9:6]) != 4'h0)
      else $error("Compensation fed by illegal source");
   stamp_cause_a:
      assert property (dst_valid_o != 6'h00 |-> $past(dig_valid_i) != 10'h000
         || $past(inv_valid_i) != 2'h0 || $past(nco_roll_i, 2) != 2'h0)
      else $error("Stamp delivered without source");
   cover property (dst_valid_o[TSX_DST_PROC]);
   cover property (pslverr_o);
   cover property (dst_valid_o[TSX_DST_SKEW] && dst_tag_o[TSX_DST_SKEW]);
endmodule // tsx_crosspoint_properties

bind tsx_crosspoint tsx_crosspoint_properties i_tsx_crosspoint_properties (
   .clk_i, .rst_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .prdata_o,
   .dig_valid_i, .inv_valid_i, .nco_roll_i, .dst_valid_o, .dst_tag_o);

// ===== bench/tsx_far_model.sv
// Behavioural loops and stamp consumers at the destinations
`timescale 1ns/1ps
module tsx_far_model
   import tsx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [TSX_NUM_DST-1:0] dst_valid_i,
   input wire logic [TSX_NUM_DST*TSX_TS_W-1:0] dst_stamp_i,
   input wire logic [TSX_NUM_DST-1:0] dst_tag_i
);
   int rx_cnt [TSX_NUM_DST];
   logic [TSX_TS_W-1:0] rx_stamp [TSX_NUM_DST];
   logic rx_tag [TSX_NUM_DST];
   // Stamp and tag kept as one unit; loops accept untagged ones too
   always @(posedge clk_i or posedge rst_i) begin
      for (int d = 0; d < TSX_NUM_DST; d++) begin
         if (rst_i) begin
            rx_cnt[d] <= 0;
         end else if (dst_valid_i[d]) begin
            rx_cnt[d] <= rx_cnt[d] + 1;
            rx_stamp[d] <= dst_stamp_i[d*TSX_TS_W+:TSX_TS_W];
            rx_tag[d] <= dst_tag_i[d];
         end
      end
   end
endmodule // tsx_far_model

// ===== bench/time_stamp_crosspoint_tagger_bench.sv
// Self-checking bench for the time stamp crosspoint
`timescale 1ns/1ps
module time_stamp_crosspoint_tagger_bench;
   import tsx_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and wiring
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [TSX_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr;
   logic [9:0] dig_v = '0;
   logic [10*TSX_TS_W-1:0] dig_s = '0;
   logic [3:0] demod = 4'h0;
   logic [1:0] mods = 2'h0, inv_v = 2'h0, inv_t = 2'h0, roll = 2'h0;
   logic [2*TSX_TS_W-1:0] inv_s = '0, nco_p = '0;
   logic [TSX_NUM_DST-1:0] dst_v, dst_t;
   logic [TSX_NUM_DST*TSX_TS_W-1:0] dst_s;
   logic [TSX_NUM_SRC*32-1:0] per;
   int n_mismatch = 0;
   int total_checks = 0;
   tsx_crosspoint i_tsx_crosspoint (.clk_i(clk), .rst_i(rst),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .dig_valid_i(dig_v), .dig_stamp_i(dig_s),
      .demod_sync_i(demod), .mod_sync_i(mods), .inv_valid_i(inv_v),
      .inv_stamp_i(inv_s), .inv_tag_i(inv_t), .nco_roll_i(roll),
      .nco_period_i(nco_p), .dst_valid_o(dst_v), .dst_stamp_o(dst_s),
      .dst_tag_o(dst_t), .src_period_o(per));
   tsx_far_model i_tsx_far_model (.clk_i(clk), .rst_i(rst),
      .dst_valid_i(dst_v), .dst_stamp_i(dst_s), .dst_tag_i(dst_t));
   initial begin
      forever #5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic test_done();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %0h", $time, what, got);
      end
   endtask
   // Waits on pready, never on a fixed count
   task automatic apb(input logic wr, input logic [15:0] idx,
                      input logic [31:0] wd, output logic err);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         n_mismatch++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic dig(input int s, input logic [47:0] st, input logic tg);
      @(posedge clk);
      dig_v[s] <= 1'b1;
      dig_s[s*TSX_TS_W+:TSX_TS_W] <= st;
      demod <= {4{tg}};
      mods <= {2{tg}};
      @(posedge clk);
      dig_v <= '0;
      @(posedge clk);
      #1;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic e;
      apb(1'b0, TSX_IDX_NCO0_RATIO, '0, e);
      chk(rd, 32'h0, "ratio0 reset");
      apb(1'b0, TSX_IDX_NCO1_RATIO, '0, e);
      chk(rd, 32'h0, "ratio1 reset");
      apb(1'b1, TSX_IDX_NCO1_RATIO, 32'h0000FFFF, e);
      apb(1'b0, TSX_IDX_NCO1_RATIO, '0, e);
      chk(rd, 32'h0000FFFF, "ratio max");
      apb(1'b0, 16'h0100, '0, e);
      chk({e, rd}, 33'h100000000, "unmapped");
      apb(1'b1, TSX_IDX_PERIOD0, 32'h00001000, e);
      apb(1'b0, TSX_IDX_PERIOD0, '0, e);
      chk(per[31:0], 32'h00001000, "period");
   endtask
   task automatic t_route();
      logic e;
      apb(1'b1, TSX_IDX_ROUTE0, 32'h10, e);
      dig(0, 48'h123456789ABC, 1'b1);
      chk(i_tsx_far_model.rx_cnt[0], 1, "ref to loop0");
      chk(i_tsx_far_model.rx_stamp[0], 48'h123456789ABC, "stamp");
      chk(i_tsx_far_model.rx_tag[0], 1'b1, "demod tag");
      apb(1'b1, TSX_IDX_ROUTE0, 32'h14, e);
      apb(1'b1, TSX_IDX_ROUTE0 + 16'h2, 32'h1A, e);
      apb(1'b0, TSX_IDX_STATUS, '0, e);
      chk(rd[2:0], 3'h5, "rejects");
      dig(0, 48'h5, 1'b0);
      chk(i_tsx_far_model.rx_cnt[0], 2, "route kept");
      apb(1'b1, TSX_IDX_ROUTE0, 32'h15, e);
      dig(5, 48'h77, 1'b1);
      chk(i_tsx_far_model.rx_tag[0], 1'b1, "fb1 to loop0");
   endtask
   task automatic t_proc();
      logic e;
      apb(1'b1, TSX_IDX_ROUTE0 + 16'h4, 32'h12, e);
      dig(2, 48'h9, 1'b0);
      chk(i_tsx_far_model.rx_cnt[4], 0, "untagged dropped");
      dig(2, 48'hA, 1'b1);
      chk(i_tsx_far_model.rx_cnt[4], 1, "tagged taken");
      apb(1'b1, TSX_IDX_ROUTE0 + 16'h2, 32'h19, e);
      dig(9, 48'hB, 1'b0);
      chk(i_tsx_far_model.rx_cnt[2], 1, "aux ref comp");
      apb(1'b1, TSX_IDX_ROUTE0 + 16'h5, 32'h1C, e);
      @(posedge clk);
      inv_v <= 2'h1;
      inv_t <= 2'h1;
      inv_s[47:0] <= 48'hC0FFEE;
      @(posedge clk);
      inv_v <= 2'h0;
      repeat (2) @(posedge clk);
      chk(i_tsx_far_model.rx_stamp[5], 48'hC0FFEE, "inverse");
   endtask
   task automatic t_nco(input logic [15:0] n, input int rolls, tags);
      logic e;
      logic [47:0] prev;
      int last, cnt;
      last = -1;
      cnt = 0;
      apb(1'b1, TSX_IDX_NCO0_RATIO, {16'h0, n}, e);
      for (int r = 0; r < rolls; r++) begin
         @(posedge clk);
         roll <= 2'h1;
         @(posedge clk);
         roll <= 2'h0;
         repeat (2) @(posedge clk);
         #1;
         if (r > 0) chk(i_tsx_far_model.rx_stamp[3] - prev, 48'h64, "step");
         prev = i_tsx_far_model.rx_stamp[3];
         if (i_tsx_far_model.rx_tag[3] === 1'b1) begin
            if (last >= 0) chk(r - last, n + 1, "tag gap");
            last = r;
            cnt++;
         end
      end
      chk(cnt, tags, "tag count");
   endtask
   task automatic t_shift();
      logic e;
      apb(1'b1, TSX_IDX_NCO0_SHIFT, 32'h0000FFFF, e);
      t_nco(16'h2, 2, 1);
      apb(1'b0, TSX_IDX_NCO0_SHIFT, '0, e);
      chk(rd, 32'h0, "shift cleared");
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic e;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      nco_p[47:0] <= 48'h64;
      t_regs();
      t_route();
      t_proc();
      apb(1'b1, TSX_IDX_ROUTE0 + 16'h3, 32'h1A, e);
      t_nco(16'h2, 9, 3);
      t_nco(16'h0, 4, 0);
      t_shift();
      test_done();
   end
endmodule // time_stamp_crosspoint_tagger_bench
